/* File: rtl/rcr_regs.svh */
// Register indices, field positions, reset values of the regulator control bank
// Assumes the includer wants plain macros; no logic here
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define RCR_IDX_B2_PRI 8'h30
`define RCR_IDX_B2_SEC 8'h31
`define RCR_IDX_B2_CTL 8'h32
`define RCR_IDX_B3_PRI 8'h40
`define RCR_IDX_B3_SEC 8'h41
`define RCR_IDX_B3_CTL 8'h42
`define RCR_IDX_L1_V 8'h50
`define RCR_IDX_L1_CTL 8'h51
`define RCR_IDX_IRQ_STAT 8'h58
`define RCR_IDX_IRQ_MASK 8'h59
`define RCR_IDX_NONE 8'hff

// ==========================================================================
// Control field positions
`define RCR_BIT_ON 7
`define RCR_BIT_PHASE 6
`define RCR_BIT_DIS 6
`define RCR_BIT_PWM 5
`define RCR_BIT_LOWQ 5
`define RCR_DLY_MSB 4
`define RCR_DLY_LSB 2
`define RCR_BIT_FIE 1
`define RCR_BIT_PG 0
`define RCR_VC_W 6

// ==========================================================================
// Reset values and fault channel positions
`define RCR_RST_VCODE 6'h00
`define RCR_RST_CTL 7'h00
`define RCR_RST_MASK 3'h0
`define RCR_CH_B2 0
`define RCR_CH_B3 1
`define RCR_CH_L1 2

`endif

/* File: rtl/rcr_pkg.sv */
// Types shared by the regulator control bank modules
// Assumes rcr_regs.svh is on the include path
`include "rcr_regs.svh"

package rcr_pkg;

  // ==========================================================================
  // Bus slave state
  typedef enum logic [1:0] {st_idle = 2'b01, st_ack = 2'b10} rcr_wb_state_e;

  typedef struct packed {
    rcr_wb_state_e st;
    logic [7:0] dat;
  } rcr_wb_s;

  // ==========================================================================
  // Register bank state
  typedef struct packed {
    logic [`RCR_VC_W-1:0] b2_pri;
    logic [`RCR_VC_W-1:0] b2_sec;
    logic [7:1] b2_ctl;
    logic [`RCR_VC_W-1:0] b3_pri;
    logic [`RCR_VC_W-1:0] b3_sec;
    logic [7:1] b3_ctl;
    logic [`RCR_VC_W-1:0] l1_v;
    logic [7:1] l1_ctl;
    logic [`RCR_VC_W-1:0] b2_out;
    logic [`RCR_VC_W-1:0] b3_out;
    logic [`RCR_VC_W-1:0] l1_out;
    logic l1_dis;
  } rcr_regs_s;

endpackage : rcr_pkg

/* File: rtl/rcr_acc_if.sv */
// Internal register access path between bus slave, bank and fault logic
// Assumes one writer of wr/idx/wdata and one driver of rdata
`timescale 1ns/1ps

interface rcr_acc_if;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output wr, output idx, output wdata, input rdata);
  modport regs (input wr, input idx, input wdata, output rdata);
  modport mon (input wr, input idx, input wdata);
endinterface : rcr_acc_if

/* File: rtl/rcr_wb_slave.sv */
// Classic Wishbone slave front end for the regulator control bank
// Assumes a single-cycle master that holds the request until ack
`timescale 1ns/1ps
`include "rcr_regs.svh"

module rcr_wb_slave (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Register access
  rcr_acc_if.bus acc
);
  rcr_pkg::rcr_wb_s q, d;
  logic take;

  // ==========================================================================
  // Read data is captured at the take edge, the write lands on the ack edge
  always_comb
  begin
    d = q;
    take = wb_cyc_i && wb_stb_i && (q.st == rcr_pkg::st_idle);
    unique case (q.st)
      rcr_pkg::st_idle:
      begin
        if (take)
        begin
          d.st = rcr_pkg::st_ack;
          d.dat = acc.rdata;
        end
      end
      rcr_pkg::st_ack: d.st = rcr_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '{st: rcr_pkg::st_idle, dat: 8'h00};
    else
      q <= d;
  end

  // Misaligned or out-of-window addresses fall on an index nothing decodes
  assign acc.idx = (wb_adr_i[31:10] == 22'h000000 && wb_adr_i[1:0] == 2'h0) ?
                   wb_adr_i[9:2] : `RCR_IDX_NONE;
  assign acc.wdata = wb_dat_i[7:0];
  assign acc.wr = (q.st == rcr_pkg::st_ack) && wb_we_i && wb_sel_i[0];
  assign wb_ack_o = (q.st == rcr_pkg::st_ack);
  assign wb_dat_o = {24'h000000, q.dat};

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_next;
    take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after take");
  c_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule : rcr_wb_slave

/* File: rtl/rcr_fault_irq.sv */
// Fault event detection, sticky status, mask and interrupt output
// Assumes power-good inputs are synchronous to clk_i
`timescale 1ns/1ps
`include "rcr_regs.svh"

module rcr_fault_irq #(
  parameter int NCH = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Channel state
  input wire logic [NCH-1:0] pgood_i,
  input wire logic [NCH-1:0] chan_en_i,
  input wire logic [NCH-1:0] chan_fie_i,
  // Register access
  rcr_acc_if.mon acc,
  // Status
  output logic [NCH-1:0] stat_o,
  output logic [NCH-1:0] mask_o,
  output logic irq_o
);
  typedef struct packed {
    logic [NCH-1:0] stat;
    logic [NCH-1:0] mask;
    logic [NCH-1:0] pg;
  } rcr_flt_s;

  rcr_flt_s q, d;
  logic [NCH-1:0] ev;
  logic [NCH-1:0] clr;

  // ==========================================================================
  // A new event beats a write-one clear in the same cycle
  always_comb
  begin
    d = q;
    ev = q.pg & ~pgood_i & chan_en_i & chan_fie_i;
    clr = (acc.wr && acc.idx == `RCR_IDX_IRQ_STAT) ? acc.wdata[NCH-1:0] : '0;
    d.stat = (q.stat & ~clr) | ev;
    if (acc.wr && acc.idx == `RCR_IDX_IRQ_MASK)
      d.mask = acc.wdata[NCH-1:0];
    d.pg = pgood_i;
  end

  // Previous power-good resets low so release never looks like a drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '{stat: '0, mask: NCH'(`RCR_RST_MASK), pg: '0};
    else
      q <= d;
  end

  assign stat_o = q.stat;
  assign mask_o = q.mask;
  assign irq_o = |(q.stat & q.mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_flt_set;
    (|ev) |=> ((stat_o & $past(ev)) == $past(ev));
  endproperty
  a_flt_set: assert property (p_flt_set) else $error("fault event not latched");

  property p_fie_gate;
    1'b1 |=> ((stat_o & ~$past(stat_o) & ~$past(chan_fie_i)) == '0);
  endproperty
  a_fie_gate: assert property (p_fie_gate) else $error("fault set while gated off");

  property p_need_drop;
    1'b1 |=> ((stat_o & ~$past(stat_o) & ($past(pgood_i) | ~$past(q.pg))) == '0);
  endproperty
  a_need_drop: assert property (p_need_drop) else $error("fault set without pg drop");

  c_flt_irq: cover property ($rose(irq_o));
endmodule : rcr_fault_irq

/* File: rtl/rcr_top.sv */
// Regulator control bank: converter two and three, linear regulator one
// Assumes synchronous inputs on clk_i and a classic Wishbone master
//
// Contract
// - Converter applies its secondary voltage code while the select pin is high.
// - Converter applies its primary voltage code while the select pin is low.
// - Control bit 7 turns the regulator on when one, off when zero.
// - Converter two bit 6 selects 180 degree phase, else in phase.
// - Converter bit 5 forces PWM at all loads, else power saving allowed.
// - Control bits 4:2 hold the turn-on delay code for the sequencer.
// - Control bit 1 allows the channel fault interrupt; zero suppresses it.
// - Control bit 0 reads the live power-good status, read only.
// - Linear regulator takes one voltage code from bits 5:0, no alternate.
// - Linear bit 6 connects the discharge path only while shut down.
// - Linear bit 5 selects low-power mode, else normal operation.
`timescale 1ns/1ps
`include "rcr_regs.svh"

module rcr_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and analog status
  input wire logic voltage_select_pin_i,
  input wire logic [2:0] pgood_i,
  // Converter two
  output logic [5:0] b2_vcode_o,
  output logic b2_en_o,
  output logic b2_phase_o,
  output logic b2_pwm_o,
  output logic [2:0] b2_delay_o,
  // Converter three
  output logic [5:0] b3_vcode_o,
  output logic b3_en_o,
  output logic b3_pwm_o,
  output logic [2:0] b3_delay_o,
  // Linear regulator one
  output logic [5:0] l1_vcode_o,
  output logic l1_en_o,
  output logic l1_discharge_o,
  output logic l1_low_quiescent_o,
  output logic [2:0] l1_delay_o,
  // Interrupt
  output logic irq_o
);
  localparam rcr_pkg::rcr_regs_s REGS_RST = '{
    b2_pri: `RCR_RST_VCODE,
    b2_sec: `RCR_RST_VCODE,
    b2_ctl: `RCR_RST_CTL,
    b3_pri: `RCR_RST_VCODE,
    b3_sec: `RCR_RST_VCODE,
    b3_ctl: `RCR_RST_CTL,
    l1_v: `RCR_RST_VCODE,
    l1_ctl: `RCR_RST_CTL,
    b2_out: `RCR_RST_VCODE,
    b3_out: `RCR_RST_VCODE,
    l1_out: `RCR_RST_VCODE,
    l1_dis: 1'b0
  };

  rcr_pkg::rcr_regs_s q, d;
  logic [2:0] stat;
  logic [2:0] mask;
  logic [2:0] chan_en;
  logic [2:0] chan_fie;

  rcr_acc_if acc ();

  // ==========================================================================
  // Helpers
  function automatic logic [`RCR_VC_W-1:0] rcr_pick(
    input logic [`RCR_VC_W-1:0] pri,
    input logic [`RCR_VC_W-1:0] sec,
    input logic sel
  );
    return sel ? sec : pri;
  endfunction : rcr_pick

  function automatic logic [7:0] rcr_ctl_rd(input logic [7:1] ctl, input logic pg);
    return {ctl, pg};
  endfunction : rcr_ctl_rd

  function automatic logic [7:0] rcr_vc_rd(input logic [`RCR_VC_W-1:0] vc);
    return {2'h0, vc};
  endfunction : rcr_vc_rd

  // ==========================================================================
  // Sub-blocks
  rcr_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .acc(acc.bus)
  );

  rcr_fault_irq #(
    .NCH(3)
  ) u_flt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pgood_i(pgood_i),
    .chan_en_i(chan_en),
    .chan_fie_i(chan_fie),
    .acc(acc.mon),
    .stat_o(stat),
    .mask_o(mask),
    .irq_o(irq_o)
  );

  assign chan_en = {q.l1_ctl[`RCR_BIT_ON], q.b3_ctl[`RCR_BIT_ON], q.b2_ctl[`RCR_BIT_ON]};
  assign chan_fie = {q.l1_ctl[`RCR_BIT_FIE], q.b3_ctl[`RCR_BIT_FIE],
                     q.b2_ctl[`RCR_BIT_FIE]};

  // ==========================================================================
  // Register writes and applied codes
  always_comb
  begin
    d = q;
    if (acc.wr)
    begin
      case (acc.idx)
        `RCR_IDX_B2_PRI: d.b2_pri = acc.wdata[`RCR_VC_W-1:0];
        `RCR_IDX_B2_SEC: d.b2_sec = acc.wdata[`RCR_VC_W-1:0];
        `RCR_IDX_B2_CTL: d.b2_ctl = acc.wdata[7:1];
        `RCR_IDX_B3_PRI: d.b3_pri = acc.wdata[`RCR_VC_W-1:0];
        `RCR_IDX_B3_SEC: d.b3_sec = acc.wdata[`RCR_VC_W-1:0];
        `RCR_IDX_B3_CTL: d.b3_ctl = acc.wdata[7:1];
        `RCR_IDX_L1_V: d.l1_v = acc.wdata[`RCR_VC_W-1:0];
        `RCR_IDX_L1_CTL: d.l1_ctl = acc.wdata[7:1];
        default: ;
      endcase
    end
    // Converter codes follow the pin live; a pin flip lands next cycle, a software change one cycle after its register write lands
    d.b2_out = rcr_pick(q.b2_pri, q.b2_sec, voltage_select_pin_i);
    d.b3_out = rcr_pick(q.b3_pri, q.b3_sec, voltage_select_pin_i);
    d.l1_out = q.l1_v;
    d.l1_dis = q.l1_ctl[`RCR_BIT_DIS] && !q.l1_ctl[`RCR_BIT_ON];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= REGS_RST;
    else
      q <= d;
  end

  // ==========================================================================
  // Read mux; the low bit of each control register is the live power-good
  always_comb
  begin
    case (acc.idx)
      `RCR_IDX_B2_PRI: acc.rdata = rcr_vc_rd(q.b2_pri);
      `RCR_IDX_B2_SEC: acc.rdata = rcr_vc_rd(q.b2_sec);
      `RCR_IDX_B2_CTL: acc.rdata = rcr_ctl_rd(q.b2_ctl, pgood_i[`RCR_CH_B2]);
      `RCR_IDX_B3_PRI: acc.rdata = rcr_vc_rd(q.b3_pri);
      `RCR_IDX_B3_SEC: acc.rdata = rcr_vc_rd(q.b3_sec);
      `RCR_IDX_B3_CTL: acc.rdata = rcr_ctl_rd(q.b3_ctl, pgood_i[`RCR_CH_B3]);
      `RCR_IDX_L1_V: acc.rdata = rcr_vc_rd(q.l1_v);
      `RCR_IDX_L1_CTL: acc.rdata = rcr_ctl_rd(q.l1_ctl, pgood_i[`RCR_CH_L1]);
      `RCR_IDX_IRQ_STAT: acc.rdata = {5'h00, stat};
      `RCR_IDX_IRQ_MASK: acc.rdata = {5'h00, mask};
      default: acc.rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // Outputs; converter three bit 6 is kept for readback only
  assign b2_vcode_o = q.b2_out;
  assign b2_en_o = q.b2_ctl[`RCR_BIT_ON];
  assign b2_phase_o = q.b2_ctl[`RCR_BIT_PHASE];
  assign b2_pwm_o = q.b2_ctl[`RCR_BIT_PWM];
  assign b2_delay_o = q.b2_ctl[`RCR_DLY_MSB:`RCR_DLY_LSB];
  assign b3_vcode_o = q.b3_out;
  assign b3_en_o = q.b3_ctl[`RCR_BIT_ON];
  assign b3_pwm_o = q.b3_ctl[`RCR_BIT_PWM];
  assign b3_delay_o = q.b3_ctl[`RCR_DLY_MSB:`RCR_DLY_LSB];
  assign l1_vcode_o = q.l1_out;
  assign l1_en_o = q.l1_ctl[`RCR_BIT_ON];
  assign l1_discharge_o = q.l1_dis;
  assign l1_low_quiescent_o = q.l1_ctl[`RCR_BIT_LOWQ];
  assign l1_delay_o = q.l1_ctl[`RCR_DLY_MSB:`RCR_DLY_LSB];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_sec_code;
    voltage_select_pin_i |=> (b2_vcode_o == $past(q.b2_sec)) &&
                             (b3_vcode_o == $past(q.b3_sec));
  endproperty
  a_sec_code: assert property (p_sec_code) else $error("secondary code not applied");

  property p_pri_code;
    !voltage_select_pin_i |=> (b2_vcode_o == $past(q.b2_pri)) &&
                              (b3_vcode_o == $past(q.b3_pri));
  endproperty
  a_pri_code: assert property (p_pri_code) else $error("primary code not applied");

  property p_en_write;
    acc.wr && acc.idx == `RCR_IDX_B2_CTL |=>
      b2_en_o == $past(acc.wdata[`RCR_BIT_ON]) ##1 b2_en_o == $past(b2_en_o);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable not following write");

  property p_phase_write;
    acc.wr && acc.idx == `RCR_IDX_B2_CTL |=> b2_phase_o == $past(acc.wdata[`RCR_BIT_PHASE]);
  endproperty
  a_phase_write: assert property (p_phase_write) else $error("phase not following write");

  property p_pwm_write;
    acc.wr && acc.idx == `RCR_IDX_B3_CTL |=> b3_pwm_o == $past(acc.wdata[`RCR_BIT_PWM]);
  endproperty
  a_pwm_write: assert property (p_pwm_write) else $error("pwm bit not following write");

  property p_delay_write;
    acc.wr && acc.idx == `RCR_IDX_L1_CTL |=>
      l1_delay_o == $past(acc.wdata[`RCR_DLY_MSB:`RCR_DLY_LSB]);
  endproperty
  a_delay_write: assert property (p_delay_write) else $error("delay code not stored");

  property p_pg_read;
    (acc.idx == `RCR_IDX_B2_CTL |-> acc.rdata[0] == pgood_i[`RCR_CH_B2]) and
    (acc.idx == `RCR_IDX_B3_CTL |-> acc.rdata[0] == pgood_i[`RCR_CH_B3]);
  endproperty
  a_pg_read: assert property (p_pg_read) else $error("power-good readback wrong");

  property p_pg_ro;
    acc.wr && acc.idx == `RCR_IDX_B2_CTL && acc.wdata[0] != pgood_i[`RCR_CH_B2] |=>
      acc.idx != `RCR_IDX_B2_CTL || acc.rdata[0] == pgood_i[`RCR_CH_B2];
  endproperty
  a_pg_ro: assert property (p_pg_ro) else $error("power-good bit took a write");

  property p_ldo_code;
    $changed(voltage_select_pin_i) |=> l1_vcode_o == $past(q.l1_v);
  endproperty
  a_ldo_code: assert property (p_ldo_code) else $error("ldo code moved with select pin");

  property p_discharge;
    ##1 l1_discharge_o == ($past(l1_en_o) == 1'b0 && $past(q.l1_ctl[`RCR_BIT_DIS]));
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge path wrong");

  property p_lowq_write;
    acc.wr && acc.idx == `RCR_IDX_L1_CTL |=>
      l1_low_quiescent_o == $past(acc.wdata[`RCR_BIT_LOWQ]);
  endproperty
  a_lowq_write: assert property (p_lowq_write) else $error("low-power mode not stored");

  property p_b3_rsvd;
    acc.wr && acc.idx == `RCR_IDX_B3_CTL &&
    ({acc.wdata[7], acc.wdata[5:1]} == {q.b3_ctl[7], q.b3_ctl[5:1]}) |=>
      $stable(b3_en_o) && $stable(b3_pwm_o) && $stable(b3_delay_o) && $stable(chan_fie);
  endproperty
  a_b3_rsvd: assert property (p_b3_rsvd) else $error("reserved bit changed operation");

  // Second set covers the fields that the write checks above leave out, all but converter two delay
  property p_b2_pwm_write;
    acc.wr && acc.idx == `RCR_IDX_B2_CTL |=> b2_pwm_o == $past(acc.wdata[`RCR_BIT_PWM]);
  endproperty
  a_b2_pwm_write: assert property (p_b2_pwm_write) else $error("b2 pwm bit not stored");

  property p_b3_ctl_write;
    acc.wr && acc.idx == `RCR_IDX_B3_CTL |=>
      b3_en_o == $past(acc.wdata[`RCR_BIT_ON]) &&
      b3_delay_o == $past(acc.wdata[`RCR_DLY_MSB:`RCR_DLY_LSB]);
  endproperty
  a_b3_ctl_write: assert property (p_b3_ctl_write) else $error("control not stored");

  property p_l1_en_write;
    acc.wr && acc.idx == `RCR_IDX_L1_CTL |=> l1_en_o == $past(acc.wdata[`RCR_BIT_ON]);
  endproperty
  a_l1_en_write: assert property (p_l1_en_write) else $error("ldo enable not stored");

  // The applied ldo code trails the landed write by one extra register stage
  property p_ldo_write;
    acc.wr && acc.idx == `RCR_IDX_L1_V |->
      ##2 l1_vcode_o == $past(acc.wdata[`RCR_VC_W-1:0], 2);
  endproperty
  a_ldo_write: assert property (p_ldo_write) else $error("ldo code not applied");

  c_sel_flip: cover property ($changed(voltage_select_pin_i) ##1 b2_vcode_o != $past(b2_vcode_o));
  c_discharge: cover property ($rose(l1_discharge_o));
  c_en_off: cover property ($fell(b2_en_o));
endmodule : rcr_top

/* File: dv/rcr_top_test.sv */
// Self-checking bench for the regulator control bank top
// Assumes the design checks its own assertions; this bench drives Wishbone and pins
`timescale 1ns/1ps
`include "rcr_regs.svh"

module rcr_top_test;
  logic clk_i;
  logic rst_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [31:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic voltage_select_pin_i;
  logic [2:0] pgood_i;
  logic [5:0] b2_vcode_o, b3_vcode_o, l1_vcode_o;
  logic b2_en_o, b2_phase_o, b2_pwm_o, b3_en_o, b3_pwm_o;
  logic l1_en_o, l1_discharge_o, l1_low_quiescent_o, irq_o;
  logic [2:0] b2_delay_o, b3_delay_o, l1_delay_o;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] wb_dat_o_unused;

  rcr_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .voltage_select_pin_i(voltage_select_pin_i),
    .pgood_i(pgood_i), .b2_vcode_o(b2_vcode_o), .b2_en_o(b2_en_o), .b2_phase_o(b2_phase_o),
    .b2_pwm_o(b2_pwm_o), .b2_delay_o(b2_delay_o), .b3_vcode_o(b3_vcode_o), .b3_en_o(b3_en_o),
    .b3_pwm_o(b3_pwm_o), .b3_delay_o(b3_delay_o), .l1_vcode_o(l1_vcode_o), .l1_en_o(l1_en_o),
    .l1_discharge_o(l1_discharge_o), .l1_low_quiescent_o(l1_low_quiescent_o),
    .l1_delay_o(l1_delay_o), .irq_o(irq_o));

  // ==========================================================================
  // Clock, reset, watchdog
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial
  begin
    // Whole run is about two hundred cycles; this leaves a wide margin
    #100000;
    n_mismatch++;
    stop_test();
  end

  // ==========================================================================
  // Shared tasks
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ad

  // Holds the request until ack is sampled high or 50 cycles pass; no fixed latency assumed
  task automatic wb_cycle(input logic we, input logic [31:0] adr, input logic [7:0] dat,
                          input logic [3:0] sel, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, dat};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
      chk({31'h0, wb_ack_o}, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_cycle

  task automatic wr(input logic [31:0] adr, input logic [7:0] dat);
    logic [31:0] rd;
    wb_cycle(1'b1, adr, dat, 4'h1, rd);
  endtask : wr

  task automatic rd_chk(input logic [31:0] adr, input logic [7:0] exp);
    logic [31:0] rd;
    wb_cycle(1'b0, adr, 8'h00, 4'hf, rd);
    chk(rd, {24'h0, exp});
  endtask : rd_chk

  // Derived outputs lag the ack edge by one cycle; sample off the edge
  task automatic look();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : look

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    look();
    chk({b2_vcode_o, b3_vcode_o, l1_vcode_o, b2_en_o, b3_en_o, l1_en_o, irq_o}, 32'h0);
    rd_chk(ad(`RCR_IDX_B2_PRI), 8'h00);
    rd_chk(ad(`RCR_IDX_B3_SEC), 8'h00);
    rd_chk(ad(`RCR_IDX_L1_V), 8'h00);
    rd_chk(ad(`RCR_IDX_IRQ_STAT), 8'h00);
    rd_chk(ad(`RCR_IDX_IRQ_MASK), 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_voltage_select_pin();
    wr(ad(`RCR_IDX_B2_PRI), 8'h15);
    wr(ad(`RCR_IDX_B2_SEC), 8'h2a);
    wr(ad(`RCR_IDX_B3_PRI), 8'hff);
    wr(ad(`RCR_IDX_B3_SEC), 8'h01);
    rd_chk(ad(`RCR_IDX_B3_PRI), 8'h3f);
    look();
    chk({b2_vcode_o, b3_vcode_o}, {20'h0, 6'h15, 6'h3f});
    @(posedge clk_i);
    voltage_select_pin_i <= 1'b1;
    look();
    chk({b2_vcode_o, b3_vcode_o}, {20'h0, 6'h2a, 6'h01});
    @(posedge clk_i);
    voltage_select_pin_i <= 1'b0;
    look();
    chk({b2_vcode_o, b3_vcode_o}, {20'h0, 6'h15, 6'h3f});
    $display("t_voltage_select_pin done");
  endtask : t_voltage_select_pin

  task automatic t_ctl();
    wr(ad(`RCR_IDX_B2_CTL), 8'hfc);
    look();
    chk({b2_en_o, b2_phase_o, b2_pwm_o, b2_delay_o}, 32'h3f);
    wr(ad(`RCR_IDX_B2_CTL), 8'h14);
    look();
    chk({b2_en_o, b2_phase_o, b2_pwm_o, b2_delay_o}, 32'h05);
    wr(ad(`RCR_IDX_B3_CTL), 8'h40);
    look();
    chk({b3_en_o, b3_pwm_o, b3_delay_o}, 32'h00);
    rd_chk(ad(`RCR_IDX_B3_CTL), 8'h41);
    wr(ad(`RCR_IDX_B3_CTL), 8'ha8);
    look();
    chk({b3_en_o, b3_pwm_o, b3_delay_o}, 32'h1a);
    $display("t_ctl done");
  endtask : t_ctl

  task automatic t_ldo();
    wr(ad(`RCR_IDX_L1_V), 8'he5);
    rd_chk(ad(`RCR_IDX_L1_V), 8'h25);
    @(posedge clk_i);
    voltage_select_pin_i <= 1'b1;
    look();
    chk({26'h0, l1_vcode_o}, 32'h25);
    @(posedge clk_i);
    voltage_select_pin_i <= 1'b0;
    wr(ad(`RCR_IDX_L1_CTL), 8'h40);
    look();
    chk({l1_en_o, l1_discharge_o, l1_low_quiescent_o, l1_delay_o}, 32'h10);
    wr(ad(`RCR_IDX_L1_CTL), 8'hc0);
    look();
    chk({l1_en_o, l1_discharge_o, l1_low_quiescent_o, l1_delay_o}, 32'h20);
    wr(ad(`RCR_IDX_L1_CTL), 8'h3c);
    look();
    chk({l1_en_o, l1_discharge_o, l1_low_quiescent_o, l1_delay_o}, 32'h0f);
    $display("t_ldo done");
  endtask : t_ldo

  task automatic t_pgood_bus();
    @(posedge clk_i);
    pgood_i <= 3'b101;
    look();
    rd_chk(ad(`RCR_IDX_B2_CTL), 8'h15);
    wr(ad(`RCR_IDX_B3_CTL), 8'ha9);
    rd_chk(ad(`RCR_IDX_B3_CTL), 8'ha8);
    rd_chk(ad(`RCR_IDX_L1_CTL), 8'h3d);
    rd_chk(ad(`RCR_IDX_IRQ_STAT), 8'h00);
    @(posedge clk_i);
    pgood_i <= 3'b111;
    wb_cycle(1'b1, ad(`RCR_IDX_B2_SEC), 8'h11, 4'he, wb_dat_o_unused);
    rd_chk(ad(`RCR_IDX_B2_SEC), 8'h2a);
    wr(ad(8'h7f), 8'h5a);
    rd_chk(ad(8'h7f), 8'h00);
    wr(ad(`RCR_IDX_B2_PRI) | 32'h1, 8'h33);
    rd_chk(ad(`RCR_IDX_B2_PRI), 8'h15);
    $display("t_pgood_bus done");
  endtask : t_pgood_bus

  task automatic t_fault();
    wr(ad(`RCR_IDX_IRQ_MASK), 8'h07);
    rd_chk(ad(`RCR_IDX_IRQ_MASK), 8'h07);
    wr(ad(`RCR_IDX_B2_CTL), 8'h82);
    wr(ad(`RCR_IDX_B3_CTL), 8'h80);
    wr(ad(`RCR_IDX_L1_CTL), 8'h02);
    look();
    // Only converter two is both enabled and allowed to report
    @(posedge clk_i);
    pgood_i <= 3'b000;
    look();
    chk({31'h0, irq_o}, 32'h1);
    rd_chk(ad(`RCR_IDX_IRQ_STAT), 8'h01);
    @(posedge clk_i);
    pgood_i <= 3'b111;
    wr(ad(`RCR_IDX_IRQ_MASK), 8'h00);
    look();
    chk({31'h0, irq_o}, 32'h0);
    rd_chk(ad(`RCR_IDX_IRQ_STAT), 8'h01);
    wr(ad(`RCR_IDX_IRQ_MASK), 8'h07);
    look();
    chk({31'h0, irq_o}, 32'h1);
    // A drop sampled on the clearing write's edge must survive the clear
    fork
      wr(ad(`RCR_IDX_IRQ_STAT), 8'h01);
      begin
        @(posedge wb_ack_o);
        pgood_i <= 3'b110;
      end
    join
    rd_chk(ad(`RCR_IDX_IRQ_STAT), 8'h01);
    @(posedge clk_i);
    pgood_i <= 3'b111;
    wr(ad(`RCR_IDX_IRQ_STAT), 8'h01);
    look();
    chk({31'h0, irq_o}, 32'h0);
    rd_chk(ad(`RCR_IDX_IRQ_STAT), 8'h00);
    $display("t_fault done");
  endtask : t_fault

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    voltage_select_pin_i = 1'b0;
    pgood_i = 3'b111;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_voltage_select_pin();
    t_ctl();
    t_ldo();
    t_pgood_bus();
    t_fault();
    stop_test();
  end
endmodule : rcr_top_test
